// ### hw/smt_core.v
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Function
// - 24-bit read/write counter, three bytes, 16-bit option
// - Captured period, width and period match registers
// - Enable clear resets state, drops clock request
// - Enable clear keeps all register contents
// - Halt-at-match holds counter, match interrupt
// - Otherwise counter wraps to zero, match interrupt
// - Window polarity selects active level and edge
// - Signal polarity selects active level and edge
// - Clock polarity selects counting clock edge
// - Prescaler divides by 1, 2, 4, 8
// - Go bit enables counting; hardware may clear
// - Repeat bit selects repeated or single acquisition
// - Mode field selects eleven operations
// - Period capture update request, cleared when done
// - Width capture update request, cleared when done
// - Manual counter reset request, cleared when done
// - Incrementing status bit reads timer activity
// - Window status bit reads window open
// - Acquisition status bit reads acquisition in progress
// - Clock source select, seven sources
// - Window source select, pin plus internal sources
// - Interrupt on acquisition complete
// - Signal source select, pin plus internal sources
`include "smt_defs.vh"

module smt_core #(
    parameter WIN_N = 18,
    parameter SIG_N = 17
) (
    input wire clk,
    input wire reset,
    input wire [4:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata,
    input wire high_freq_internal_osc,
    input wire low_freq_internal_osc,
    input wire mid_freq_internal_osc,
    input wire secondary_oscillator,
    input wire [WIN_N-1:0] window_input,
    input wire [SIG_N-1:0] measured_signal,
    output reg period_match_irq,
    output reg acq_done_irq,
    output reg clock_request
);
    localparam NIN = 4 + WIN_N + SIG_N;

    reg [7:0] con0_r, con1_r, stat_hi_r, clksel_r, winsel_r, sigsel_r;
    reg width16_r;
    reg [23:0] tmr_r, cpr_r, cpw_r, pr_r;
    reg [NIN-1:0] s1_r, s2_r, s3_r;
    reg [1:0] f4_r;
    reg [3:0] mf16_r;
    reg [2:0] ps_r;
    reg win_prev_r, sig_prev_r, acq_r, seen_r;

    wire en = con0_r[`SMT_EN_BIT];
    wire go = con1_r[`SMT_GO_BIT];
    wire run = en & go;
    wire [3:0] mode = con1_r[3:0];
    wire wr = wr_stb;

    // First stage feeds no logic; second stage gives the levels, third stage is the edge history
    always @(posedge clk) begin
        if (reset) begin
            s1_r <= {NIN{1'b0}};
            s2_r <= {NIN{1'b0}};
            s3_r <= {NIN{1'b0}};
        end else begin
            s1_r <= {measured_signal, window_input, secondary_oscillator,
                     mid_freq_internal_osc, low_freq_internal_osc,
                     high_freq_internal_osc};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Oscillator edges per chosen polarity
    wire [3:0] osc_now = s2_r[3:0];
    wire [3:0] osc_old = s3_r[3:0];
    wire [3:0] osc_edge = con0_r[`SMT_CLOCK_POLARITY_BIT] ?
        (osc_old & ~osc_now) : (~osc_old & osc_now);

    // Source selection
    reg src_tick;
    always @* begin
        case (clksel_r[2:0])
            `SMT_C_FOSC4: src_tick = (f4_r == `SMT_FOSC4_DIV);
            `SMT_C_FOSC: src_tick = 1'b1;
            `SMT_C_HF: src_tick = osc_edge[0];
            `SMT_C_LF: src_tick = osc_edge[1];
            `SMT_C_MF: src_tick = osc_edge[2];
            `SMT_C_MF16: src_tick = osc_edge[2] &
                (mf16_r == `SMT_MF16_DIV);
            `SMT_C_SECONDARY_OSCILLATOR: src_tick = osc_edge[3];
            default: src_tick = 1'b0;
        endcase
    end

    reg [2:0] ps_mask;
    always @* begin
        case (con0_r[1:0])
            2'h0: ps_mask = 3'h0;
            2'h1: ps_mask = 3'h1;
            2'h2: ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    end
    wire tick = src_tick & ((ps_r & ps_mask) == ps_mask);

    // Window source: codes 7 and 8 are the same capture output
    wire [WIN_N-1:0] win_v = s2_r[4 +: WIN_N];
    wire [WIN_N-1:0] win_o = s3_r[4 +: WIN_N];
    wire [4:0] window_source_select = winsel_r[4:0];
    wire [4:0] widx = (window_source_select > 5'h07) ? (window_source_select - 5'h01) : window_source_select;
    wire w_ok = (window_source_select <= 5'h12);
    wire w_raw = w_ok & win_v[widx];
    wire w_old = w_ok & win_o[widx];
    wire [SIG_N-1:0] sig_v = s2_r[4 + WIN_N +: SIG_N];
    wire [SIG_N-1:0] sig_o = s3_r[4 + WIN_N +: SIG_N];
    wire [4:0] ssel = sigsel_r[4:0];
    wire s_ok = (ssel <= 5'h10);
    wire s_raw = s_ok & sig_v[ssel];
    wire s_old = s_ok & sig_o[ssel];

    wire win_act = w_raw ^ con0_r[`SMT_WINDOW_POLARITY_BIT];
    wire win_was = w_old ^ con0_r[`SMT_WINDOW_POLARITY_BIT];
    wire sig_act = s_raw ^ con0_r[`SMT_SIGNAL_POLARITY_BIT];
    wire sig_was = s_old ^ con0_r[`SMT_SIGNAL_POLARITY_BIT];
    wire win_rise = run & win_act & ~win_was;
    wire win_fall = run & ~win_act & win_was;
    wire sig_rise = run & sig_act & ~sig_was;
    wire sig_fall = run & ~sig_act & sig_was;

    // Mode sequencing: increment, capture, restart, complete
    reg inc, cap_pr, cap_pw, restart, done, start;
    always @* begin
        inc = 1'b0;
        cap_pr = 1'b0;
        cap_pw = 1'b0;
        restart = 1'b0;
        done = 1'b0;
        start = 1'b0;
        case (mode)
            `SMT_M_TIMER: begin
                inc = tick;
                start = run;
            end
            `SMT_M_GTIMER: begin
                inc = tick & sig_act;
                start = run;
            end
            `SMT_M_PERDUTY: begin
                inc = tick & acq_r;
                cap_pw = sig_fall & acq_r;
                cap_pr = sig_rise & acq_r;
                done = cap_pr;
                restart = sig_rise;
                start = sig_rise;
            end
            `SMT_M_HILO: begin
                inc = tick & acq_r;
                cap_pw = sig_fall & acq_r;
                cap_pr = sig_rise & seen_r;
                done = cap_pr;
                restart = sig_rise | sig_fall;
                start = sig_rise;
            end
            `SMT_M_WINMEAS: begin
                inc = tick & acq_r;
                cap_pr = win_rise & acq_r;
                done = cap_pr;
                restart = win_rise;
                start = win_rise;
            end
            `SMT_M_GWINMEAS: begin
                inc = tick & acq_r & sig_act;
                cap_pw = win_rise & acq_r;
                done = cap_pw;
                restart = win_rise;
                start = win_rise;
            end
            `SMT_M_TOF: begin
                inc = tick & acq_r;
                cap_pr = win_rise & acq_r;
                cap_pw = sig_rise & acq_r;
                done = cap_pw;
                restart = win_rise;
                start = win_rise;
            end
            `SMT_M_CAPTURE: begin
                inc = tick;
                cap_pw = sig_rise;
                cap_pr = win_rise;
                done = sig_rise;
                start = run;
            end
            `SMT_M_COUNTER: begin
                inc = sig_rise;
                start = run;
            end
            `SMT_M_GCOUNTER: begin
                inc = sig_rise & win_act;
                cap_pw = win_fall;
                done = win_fall;
                restart = win_rise;
                start = win_rise;
            end
            `SMT_M_WCOUNTER: begin
                inc = sig_rise & acq_r;
                cap_pw = win_rise & acq_r;
                done = cap_pw;
                restart = win_rise;
                start = win_rise;
            end
            default: begin
                inc = 1'b0;
            end
        endcase
    end

    wire single_end = done & ~con1_r[`SMT_REP_BIT];
    wire [23:0] cnt_mask = width16_r ? 24'h00FFFF : 24'hFFFFFF;
    wire [23:0] tmr_m = tmr_r & cnt_mask;
    wire [23:0] pr_m = pr_r & cnt_mask;
    wire at_match = (tmr_m == pr_m);
    wire match_ev = run & inc & at_match;

    // Internal operating state
    always @(posedge clk) begin
        if (reset || !en) begin
            f4_r <= 2'h0;
            mf16_r <= 4'h0;
            ps_r <= 3'h0;
            acq_r <= 1'b0;
            seen_r <= 1'b0;
            clock_request <= 1'b0;
        end else begin
            f4_r <= f4_r + 2'h1;
            if (osc_edge[2])
                mf16_r <= mf16_r + 4'h1;
            if (src_tick && go)
                ps_r <= ps_r + 3'h1;
            clock_request <= go;
            if (!go || single_end)
                acq_r <= 1'b0;
            else if (start)
                acq_r <= 1'b1;
            if (!go)
                seen_r <= 1'b0;
            else if (sig_fall && acq_r)
                seen_r <= 1'b1;
        end
    end

    // Interrupt pulses
    always @(posedge clk) begin
        if (reset) begin
            period_match_irq <= 1'b0;
            acq_done_irq <= 1'b0;
        end else begin
            period_match_irq <= match_ev;
            acq_done_irq <= run & done;
        end
    end

    // Register file; enable clear touches none of these
    wire sw_stat = wr && (addr == `SMT_A_STAT);
    always @(posedge clk) begin
        if (reset) begin
            con0_r <= `SMT_RST_BYTE;
            con1_r <= `SMT_RST_BYTE;
            stat_hi_r <= `SMT_RST_BYTE;
            clksel_r <= `SMT_RST_BYTE;
            winsel_r <= `SMT_RST_BYTE;
            sigsel_r <= `SMT_RST_BYTE;
            width16_r <= 1'b0;
            tmr_r <= `SMT_RST_CNT;
            cpr_r <= `SMT_RST_CNT;
            cpw_r <= `SMT_RST_CNT;
            pr_r <= `SMT_RST_PR;
        end else begin
            // Counter: software write wins over hardware update
            if (wr && addr == `SMT_A_TMR_L)
                tmr_r[7:0] <= wdata;
            else if (wr && addr == `SMT_A_TMR_H)
                tmr_r[15:8] <= wdata;
            else if (wr && addr == `SMT_A_TMR_U)
                tmr_r[23:16] <= wdata;
            else if (stat_hi_r[`SMT_RST_BIT] || (run && restart))
                tmr_r <= `SMT_RST_CNT;
            else if (run && inc) begin
                if (!at_match)
                    tmr_r <= (tmr_m + 24'h000001) & cnt_mask;
                else if (!con0_r[`SMT_STOP_BIT])
                    tmr_r <= `SMT_RST_CNT;
                else
                    tmr_r <= tmr_r;
            end
            if (stat_hi_r[`SMT_PERIOD_CAPTURE_UPDATE_BIT] || (run && cap_pr))
                cpr_r <= tmr_m;
            if (stat_hi_r[`SMT_WIDTH_CAPTURE_UPDATE_BIT] || (run && cap_pw))
                cpw_r <= tmr_m;
            // Requests complete in one cycle; a new write wins the clear
            if (sw_stat)
                stat_hi_r <= wdata & 8'hE0;
            else
                stat_hi_r <= `SMT_RST_BYTE;
            if (wr && addr == `SMT_A_CON0)
                con0_r <= wdata & `SMT_CON0_MASK;
            if (wr && addr == `SMT_A_CON1)
                con1_r <= wdata & `SMT_CON1_MASK;
            else if (en && single_end)
                con1_r[`SMT_GO_BIT] <= 1'b0;
            if (wr && addr == `SMT_A_CLK)
                clksel_r <= wdata & `SMT_CLK_MASK;
            if (wr && addr == `SMT_A_WIN)
                winsel_r <= wdata & `SMT_SEL_MASK;
            if (wr && addr == `SMT_A_SIG)
                sigsel_r <= wdata & `SMT_SEL_MASK;
            if (wr && addr == `SMT_A_CFG)
                width16_r <= wdata[0];
            if (wr && addr == `SMT_A_PR_L)
                pr_r[7:0] <= wdata;
            if (wr && addr == `SMT_A_PR_H)
                pr_r[15:8] <= wdata;
            if (wr && addr == `SMT_A_PR_U)
                pr_r[23:16] <= wdata;
        end
    end

    // Read path
    wire [7:0] stat_rd = {stat_hi_r[7:5], 2'b00,
                          run,
                          win_act,
                          acq_r};
    reg [7:0] rd_nxt;
    always @* begin
        case (addr)
            `SMT_A_CON0: rd_nxt = con0_r;
            `SMT_A_CON1: rd_nxt = con1_r;
            `SMT_A_STAT: rd_nxt = stat_rd;
            `SMT_A_CLK: rd_nxt = clksel_r;
            `SMT_A_WIN: rd_nxt = winsel_r;
            `SMT_A_SIG: rd_nxt = sigsel_r;
            `SMT_A_TMR_L: rd_nxt = tmr_r[7:0];
            `SMT_A_TMR_H: rd_nxt = tmr_r[15:8];
            `SMT_A_TMR_U: rd_nxt = tmr_r[23:16];
            `SMT_A_CPR_L: rd_nxt = cpr_r[7:0];
            `SMT_A_CPR_H: rd_nxt = cpr_r[15:8];
            `SMT_A_CPR_U: rd_nxt = cpr_r[23:16];
            `SMT_A_CPW_L: rd_nxt = cpw_r[7:0];
            `SMT_A_CPW_H: rd_nxt = cpw_r[15:8];
            `SMT_A_CPW_U: rd_nxt = cpw_r[23:16];
            `SMT_A_PR_L: rd_nxt = pr_r[7:0];
            `SMT_A_PR_H: rd_nxt = pr_r[15:8];
            `SMT_A_PR_U: rd_nxt = pr_r[23:16];
            `SMT_A_CFG: rd_nxt = {7'h00, width16_r};
            default: rd_nxt = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (reset)
            rdata <= 8'h00;
        else if (rd_stb)
            rdata <= rd_nxt;
        else
            rdata <= 8'h00;
    end
endmodule

// ### shared/smt_defs.vh
`ifndef SMT_DEFS_VH
`define SMT_DEFS_VH

// Register byte offsets
`define SMT_A_CON0      5'h00
`define SMT_A_CON1      5'h01
`define SMT_A_STAT      5'h02
`define SMT_A_CLK       5'h03
`define SMT_A_WIN       5'h04
`define SMT_A_SIG       5'h05
`define SMT_A_TMR_L     5'h06
`define SMT_A_TMR_H     5'h07
`define SMT_A_TMR_U     5'h08
`define SMT_A_CPR_L     5'h09
`define SMT_A_CPR_H     5'h0A
`define SMT_A_CPR_U     5'h0B
`define SMT_A_CPW_L     5'h0C
`define SMT_A_CPW_H     5'h0D
`define SMT_A_CPW_U     5'h0E
`define SMT_A_PR_L      5'h0F
`define SMT_A_PR_H      5'h10
`define SMT_A_PR_U      5'h11
`define SMT_A_CFG       5'h12

// Field positions
`define SMT_EN_BIT      7
`define SMT_STOP_BIT    5
`define SMT_WINDOW_POLARITY_BIT    4
`define SMT_SIGNAL_POLARITY_BIT    3
`define SMT_CLOCK_POLARITY_BIT    2
`define SMT_GO_BIT      7
`define SMT_REP_BIT     6
`define SMT_PERIOD_CAPTURE_UPDATE_BIT   7
`define SMT_WIDTH_CAPTURE_UPDATE_BIT   6
`define SMT_RST_BIT     5

// Reset values
`define SMT_RST_BYTE    8'h00
`define SMT_RST_PR      24'hFFFFFF
`define SMT_RST_CNT     24'h000000

// Writable masks
`define SMT_CON0_MASK   8'hBF
`define SMT_CON1_MASK   8'hCF
`define SMT_CLK_MASK    8'h07
`define SMT_SEL_MASK    8'h1F

// Modes
`define SMT_M_TIMER     4'h0
`define SMT_M_GTIMER    4'h1
`define SMT_M_PERDUTY   4'h2
`define SMT_M_HILO      4'h3
`define SMT_M_WINMEAS   4'h4
`define SMT_M_GWINMEAS  4'h5
`define SMT_M_TOF       4'h6
`define SMT_M_CAPTURE   4'h7
`define SMT_M_COUNTER   4'h8
`define SMT_M_GCOUNTER  4'h9
`define SMT_M_WCOUNTER  4'hA

// Clock sources
`define SMT_C_FOSC4     3'h0
`define SMT_C_FOSC      3'h1
`define SMT_C_HF        3'h2
`define SMT_C_LF        3'h3
`define SMT_C_MF        3'h4
`define SMT_C_MF16      3'h5
`define SMT_C_SECONDARY_OSCILLATOR      3'h6

// Timing counts
`define SMT_FOSC4_DIV   2'h3
`define SMT_MF16_DIV    4'hF

`endif

// ### verif/smt_core_asserts.sv
`timescale 1ns/1ns
`include "smt_defs.vh"
module smt_core_asserts (
    input wire clk,
    input wire reset,
    input wire [4:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] rdata,
    input wire period_match_irq,
    input wire acq_done_irq,
    input wire clock_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence en_off_s;
        wr_stb && addr == `SMT_A_CON0 && !wdata[`SMT_EN_BIT];
    endsequence
    sequence clk_wr_s;
        wr_stb && addr == `SMT_A_CLK;
    endsequence
    sequence clk_rd_s;
        rd_stb && addr == `SMT_A_CLK;
    endsequence
    sequence win_wr_s;
        wr_stb && addr == `SMT_A_WIN;
    endsequence
    sequence win_rd_s;
        rd_stb && addr == `SMT_A_WIN;
    endsequence

    rdata_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
        else $error("read data not idle");
    unmapped_zero_a: assert property (rd_stb && addr > `SMT_A_CFG
        |=> rdata == 8'h00) else $error("unmapped read not zero");
    en_off_req_a: assert property (en_off_s |-> ##2 !clock_request)
        else $error("clock request after disable");
    go_off_req_a: assert property (wr_stb && addr == `SMT_A_CON1
        && !wdata[`SMT_GO_BIT] |-> ##2 !clock_request)
        else $error("clock request after go cleared");
    ts_status_a: assert property (rd_stb && addr == `SMT_A_STAT
        |=> rdata[2] == clock_request) else $error("status bit 2 wrong");
    clk_rdback_a: assert property (clk_wr_s ##2 clk_rd_s
        |=> rdata == ($past(wdata, 3) & `SMT_CLK_MASK))
        else $error("clock select readback wrong");
    win_rdback_a: assert property (win_wr_s ##2 win_rd_s
        |=> rdata == ($past(wdata, 3) & `SMT_SEL_MASK))
        else $error("window select readback wrong");
    off_quiet_a: assert property (en_off_s
        |-> ##3 (!period_match_irq && !acq_done_irq) [*4])
        else $error("interrupt while disabled");
endmodule

bind smt_core smt_core_asserts i_chk (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .period_match_irq(period_match_irq),
    .acq_done_irq(acq_done_irq), .clock_request(clock_request));

// ### verif/testbench.sv
`timescale 1ns/1ns
`include "smt_defs.vh"
module testbench;
    reg clk;
    reg reset;
    reg [4:0] addr;
    reg [7:0] wdata;
    reg wr_stb;
    reg rd_stb;
    wire [7:0] rdata;
    reg [3:0] osc_cnt;
    reg [17:0] window_input;
    reg [16:0] measured_signal;
    wire period_match_irq;
    wire acq_done_irq;
    wire clock_request;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    reg rd_d;
    int n_mismatch;
    int check_count;
    int cycles;
    int n;
    int ps;
    int per;
    int i;

    smt_core i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .high_freq_internal_osc(osc_cnt[0]),
        .low_freq_internal_osc(osc_cnt[2]),
        .mid_freq_internal_osc(osc_cnt[1]),
        .secondary_oscillator(osc_cnt[3]), .window_input(window_input),
        .measured_signal(measured_signal),
        .period_match_irq(period_match_irq), .acq_done_irq(acq_done_irq),
        .clock_request(clock_request));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs about a thousand cycles
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 4'h1;
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d) begin
            note = exp_q.pop_front();
            check_count = check_count + 1;
            if ((rdata & note[15:8]) !== note[7:0]) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0t read %h exp %h", $time, rdata, note[7:0]);
            end
        end
        rd_d <= rd_stb;
    end

    task automatic chk(input logic ok, input string msg);
        check_count = check_count + 1;
        if (ok !== 1'b1) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic wr(input [4:0] a, input [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input [4:0] a, input [7:0] m, input [7:0] e);
        exp_q.push_back({m, e & m});
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
    endtask

    task automatic wait_ev(input bit acq, output int cnt);
        cnt = 0;
        do begin
            // Mid-cycle sample: the pulse launched at the edge has settled
            @(negedge clk);
            cnt = cnt + 1;
        end while ((acq ? acq_done_irq : period_match_irq) !== 1'b1
            && cnt < 3000);
        chk(cnt < 3000, "event missing");
    endtask

    initial begin
        reset = 1'b1;
        addr = 5'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        rd_d = 1'b0;
        osc_cnt = 4'h0;
        cycles = 0;
        n_mismatch = 0;
        check_count = 0;
        n = $urandom(32'h7A067B09);
        window_input = $urandom & 18'h3FFFE;
        measured_signal = $urandom & 17'h1FFFE;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 19; i++)
            rd(i[4:0], 8'hFF, (i >= 15 && i <= 17) ? 8'hFF : 8'h00);
        rd(5'h1F, 8'hFF, 8'h00);
        $display("reset values done");
        for (i = 0; i < 16; i++) begin
            n = ($urandom & 8'h40) | i;
            wr(`SMT_A_CON1, n[7:0]);
            rd(`SMT_A_CON1, 8'hFF, n[7:0]);
        end
        for (i = 0; i < 12; i++) begin
            ps = `SMT_A_CLK + i % 3;
            n = $urandom;
            wr(ps[4:0], n[7:0]);
            rd(ps[4:0], 8'hFF, n[7:0] &
                ((i % 3) ? `SMT_SEL_MASK : `SMT_CLK_MASK));
        end
        wr(`SMT_A_CPR_L, 8'h5A);
        rd(`SMT_A_CPR_L, 8'hFF, 8'h00);
        wr(`SMT_A_TMR_U, 8'hA5);
        rd(`SMT_A_TMR_U, 8'hFF, 8'hA5);
        wr(`SMT_A_CFG, 8'h01);
        rd(`SMT_A_CFG, 8'hFF, 8'h01);
        wr(`SMT_A_CLK, {5'h00, `SMT_C_FOSC});
        wr(`SMT_A_WIN, 8'h00);
        wr(`SMT_A_SIG, 8'h00);
        $display("register access done");
        for (ps = 0; ps < 4; ps++) begin
            per = 3 + $urandom % 8;
            wr(`SMT_A_CON0, 8'h00);
            wr(`SMT_A_STAT, 8'h20);
            wr(`SMT_A_PR_L, per[7:0]);
            wr(`SMT_A_PR_H, 8'h00);
            n = $urandom;
            wr(`SMT_A_PR_U, n[7:0] | 8'h01);
            wr(`SMT_A_CON1, 8'hC0);
            wr(`SMT_A_CON0, 8'h80 | ps[7:0]);
            wait_ev(1'b0, n);
            wait_ev(1'b0, n);
            chk(n == ((per + 1) << ps), "match spacing");
        end
        // Slow source: falling-edge counting is half a source period late
        wr(`SMT_A_CLK, {5'h00, `SMT_C_LF});
        for (i = 0; i < 2; i++) begin
            wr(`SMT_A_CON0, {5'h10, i[0], 2'h0});
            wait_ev(1'b0, n);
            wait_ev(1'b0, n);
            chk(n == 8 * (per + 1), "slow clock spacing");
            ps = (i == 0) ? osc_cnt : ps - osc_cnt;
        end
        chk(ps[2:0] == 3'h4, "clock edge phase");
        chk(clock_request === 1'b1, "no clock request");
        $display("prescale done");
        wr(`SMT_A_CON0, 8'hA0);
        wait_ev(1'b0, n);
        wait_ev(1'b0, n);
        rd(`SMT_A_TMR_L, 8'hFF, per[7:0]);
        rd(`SMT_A_TMR_H, 8'hFF, 8'h00);
        wr(`SMT_A_STAT, 8'hC0);
        repeat (2) @(posedge clk);
        rd(`SMT_A_CPR_L, 8'hFF, per[7:0]);
        rd(`SMT_A_CPW_L, 8'hFF, per[7:0]);
        wr(`SMT_A_CON0, 8'h00);
        rd(`SMT_A_TMR_L, 8'hFF, per[7:0]);
        rd(`SMT_A_PR_L, 8'hFF, per[7:0]);
        rd(`SMT_A_CON1, 8'hFF, 8'hC0);
        chk(clock_request === 1'b0, "request kept");
        wr(`SMT_A_STAT, 8'h20);
        repeat (2) @(posedge clk);
        rd(`SMT_A_TMR_L, 8'hFF, 8'h00);
        rd(`SMT_A_STAT, 8'hE0, 8'h00);
        $display("halt and manual update done");
        for (i = 0; i < 2; i++) begin
            measured_signal[0] <= i[0];
            wr(`SMT_A_CON0, {4'h8, i[0], 3'h0});
            wr(`SMT_A_CON1, 8'h87);
            rd(`SMT_A_STAT, 8'h05, 8'h05);
            measured_signal[0] <= ~i[0];
            wait_ev(1'b1, n);
            chk(n < 10, "capture late");
            rd(`SMT_A_CON1, 8'hFF, 8'h07);
            rd(`SMT_A_STAT, 8'h05, 8'h00);
        end
        // Counter mode: six toggles give three active edges
        wr(`SMT_A_CON1, 8'hC8);
        wr(`SMT_A_STAT, 8'h20);
        for (i = 0; i < 6; i++) begin
            measured_signal[0] <= ~measured_signal[0];
            repeat (4) @(posedge clk);
        end
        rd(`SMT_A_TMR_L, 8'hFF, 8'h03);
        $display("capture done");
        wr(`SMT_A_CON0, 8'h80);
        window_input[0] <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`SMT_A_STAT, 8'h02, 8'h02);
        wr(`SMT_A_CON0, 8'h90);
        repeat (2) @(posedge clk);
        rd(`SMT_A_STAT, 8'h02, 8'h00);
        repeat (3) @(posedge clk);
        $display("window status done");
        give_verdict();
    end
endmodule
